// ### itrp_pkg.sv
// Purpose: Shared constants and types for the interval timer host port.
// Assumes: Three counters behind one 8-bit port with four addresses.
// Notes:   Field positions and encodings of the command and status bytes.
// Summary of operation
// - A new count is taken any time in the current byte format; mode stays.
// - Control write with bits 5:4 zero latches the count of counter bits 7:6.
// - Latched snapshot holds until read or reprogram, then follows the count.
// - A second latch request before the read is ignored.
// - Counts read in programmed format; two-byte reads may be interleaved.
// - Read and write byte sequencing are independent per counter.
// - Read-back: bits 7:6 set, bit5 count, bit4 status, bits 3:1 select.
// - Read-back count latches all selected counters like separate latches.
// - Repeated read-back count latches on an unread counter are ignored.
// - Status is read at the counter port only after a status latch.
// - Status byte: output level, load pending, then last programmed fields.
// - Load pending sets on mode word or count write, clears on transfer.
// - Two-byte counts raise load pending only after the second byte.
// - Repeated status latches on an unread status are ignored.
// - Status is read first, then latched count bytes, then live count.
// - Strobe and address decode; other combinations leave the bus released.
// - Counter clock pulse is rise then fall; load moves holding to counter.
// - Gate rising edge is a trigger event for the mode logic.
// - Mode word: counter select, byte format, mode, decimal select.
// - Counting element is a 16-bit presettable down counter, never direct.
// - Single-byte formats clear the unused holding register byte.
package itrp_pkg;
   localparam int          NUM_CTR     = 3;
   localparam int          CNT_W       = 16;
   localparam logic [1:0]  PORT_CTRL   = 2'h3;
   localparam logic [1:0]  SEL_RDBACK  = 2'h3;
   localparam int          CW_SEL_LSB  = 6;
   localparam int          CW_FMT_LSB  = 4;
   localparam int          CW_FIELD_W  = 6;
   localparam logic [1:0]  FMT_LATCH   = 2'h0;
   localparam logic [1:0]  FMT_LOW     = 2'h1;
   localparam logic [1:0]  FMT_HIGH    = 2'h2;
   localparam logic [1:0]  FMT_BOTH    = 2'h3;
   localparam int          RB_COUNT_N  = 5;
   localparam int          RB_STATUS_N = 4;
   localparam int          RB_SEL_LSB  = 1;
   localparam logic [7:0]  ZERO_BYTE   = 8'h00;
   localparam logic [15:0] ZERO_COUNT  = 16'h0000;
   localparam logic [5:0]  CTRL_RESET  = 6'h00;

   typedef enum logic [1:0] {
      ITRP_BYTE_LOW  = 2'b01,
      ITRP_BYTE_HIGH = 2'b10
   } itrp_byte_type;

   function automatic logic itrp_two_byte(input logic [1:0] fmt);
      return fmt == FMT_BOTH;
   endfunction

   function automatic logic itrp_high_byte(input logic [1:0] fmt, input itrp_byte_type ptr);
      return (fmt == FMT_HIGH) || (itrp_two_byte(fmt) && ptr == ITRP_BYTE_HIGH);
   endfunction
endpackage

// ### itrp_edge_detect.sv
// Purpose: Finds counter clock pulses and gate triggers for all counters.
// Assumes: Counter clock and gate inputs are synchronous to clk.
// Notes:   A clock pulse is reported on the falling edge that ends it.
`timescale 1ns/1ps
`default_nettype none
module itrp_edge_detect #(
   parameter int N = itrp_pkg::NUM_CTR
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         reset,
   // Counter pins.
   input  wire logic [N-1:0] timer_clk,
   input  wire logic [N-1:0] gate,
   // Events.
   output logic      [N-1:0] clk_pulse,
   output logic      [N-1:0] trigger
);
   import itrp_pkg::*;

   typedef struct packed {
      logic [N-1:0] clk_d;
      logic [N-1:0] armed;
      logic [N-1:0] gate_d;
      logic [N-1:0] pulse;
      logic [N-1:0] trig;
   } itrp_edge_state_type;

   itrp_edge_state_type st;
   itrp_edge_state_type next_st;

   always_comb begin
      next_st        = st;
      next_st.clk_d  = timer_clk;
      next_st.gate_d = gate;
      for (int i = 0; i < N; i++) begin
         next_st.pulse[i] = st.armed[i] && st.clk_d[i] && !timer_clk[i];
         if (!st.clk_d[i] && timer_clk[i]) begin
            next_st.armed[i] = 1'b1;
         end else if (next_st.pulse[i]) begin
            next_st.armed[i] = 1'b0;
         end
         next_st.trig[i] = !st.gate_d[i] && gate[i];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign clk_pulse = st.pulse;
   assign trigger   = st.trig;
endmodule // itrp_edge_detect
`default_nettype wire

// ### itrp_count_elem.sv
// Purpose: One counting element, preset from the holding register.
// Assumes: Mode logic outside asks for loads and enables counting.
// Notes:   Loading and counting both happen only on a counter clock pulse.
`timescale 1ns/1ps
`default_nettype none
module itrp_count_elem #(
   parameter int W = itrp_pkg::CNT_W
) (
   // Clock and reset.
   input  wire logic         clk,
   input  wire logic         reset,
   // Control.
   input  wire logic [W-1:0] preset,
   input  wire logic         load_req,
   input  wire logic         count_en,
   input  wire logic         clk_pulse,
   // State.
   output logic      [W-1:0] count,
   output logic              load_done
);
   import itrp_pkg::*;

   typedef struct packed {
      logic [W-1:0] count;
      logic         done;
   } itrp_ce_state_type;

   itrp_ce_state_type st;
   itrp_ce_state_type next_st;

   always_comb begin
      next_st      = st;
      next_st.done = 1'b0;
      if (clk_pulse && load_req) begin
         next_st.count = preset;
         next_st.done  = 1'b1;
      end else if (clk_pulse && count_en) begin
         next_st.count = st.count - W'(1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count     = st.count;
   assign load_done = st.done;
endmodule // itrp_count_elem
`default_nettype wire

// ### itrp_host_port.sv
// Purpose: Host access logic of a three-counter interval timer.
// Assumes: Bus strobes and counter pins are synchronous to clk.
// Notes:   Per-mode waveforms live in the mode logic outside this block.
`timescale 1ns/1ps
`default_nettype none
module itrp_host_port (
   // Clock and reset.
   input  wire logic                         clk,
   input  wire logic                         reset,
   // Processor bus.
   input  wire logic                         chip_sel_n,
   input  wire logic                         rd_n,
   input  wire logic                         wr_n,
   input  wire logic                         port_sel_hi,
   input  wire logic                         port_sel_lo,
   input  wire logic [7:0]                   data_in,
   output logic      [7:0]                   data_out,
   output logic                              data_oe_n,
   // Counter pins.
   input  wire logic [itrp_pkg::NUM_CTR-1:0] timer_clk,
   input  wire logic [itrp_pkg::NUM_CTR-1:0] gate,
   // Mode logic.
   input  wire logic [itrp_pkg::NUM_CTR-1:0] out_level,
   input  wire logic [itrp_pkg::NUM_CTR-1:0] load_req,
   input  wire logic [itrp_pkg::NUM_CTR-1:0] count_en,
   output logic      [itrp_pkg::NUM_CTR-1:0] clk_pulse,
   output logic      [itrp_pkg::NUM_CTR-1:0] trigger,
   output logic      [itrp_pkg::NUM_CTR-1:0] load_done,
   output logic      [itrp_pkg::NUM_CTR-1:0] count_written,
   output logic      [itrp_pkg::NUM_CTR-1:0] mode_written,
   output logic      [itrp_pkg::NUM_CTR*6-1:0] mode_word
);
   import itrp_pkg::*;

   typedef struct packed {
      logic [NUM_CTR-1:0][CW_FIELD_W-1:0] ctrl;
      logic [NUM_CTR-1:0][CNT_W-1:0]      cr;
      logic [NUM_CTR-1:0][CNT_W-1:0]      ol;
      logic [NUM_CTR-1:0][7:0]            sts;
      logic [NUM_CTR-1:0]                 cnt_lat;
      logic [NUM_CTR-1:0]                 sts_lat;
      logic [NUM_CTR-1:0]                 null_cnt;
      itrp_byte_type [NUM_CTR-1:0]        rd_ptr;
      itrp_byte_type [NUM_CTR-1:0]        wr_ptr;
      logic                               wr_n_d;
      logic                               rd_n_d;
      logic [7:0]                         data_out;
      logic                               data_oe_n;
      logic [NUM_CTR-1:0]                 written;
      logic [NUM_CTR-1:0]                 mode_wr;
   } itrp_state_type;

   itrp_state_type                  st;
   itrp_state_type                  next_st;
   logic [NUM_CTR-1:0][CNT_W-1:0]   live;
   logic [NUM_CTR-1:0]              ce_done;
   logic [NUM_CTR-1:0]              pulse;

   itrp_edge_detect #(
      .N (NUM_CTR)
   ) u_edge (
      .clk       (clk),
      .reset     (reset),
      .timer_clk (timer_clk),
      .gate      (gate),
      .clk_pulse (pulse),
      .trigger   (trigger)
   );

   // Each counting element is loaded from its holding register.
   for (genvar g = 0; g < NUM_CTR; g++) begin : g_ce
      itrp_count_elem #(
         .W (CNT_W)
      ) u_ce (
         .clk       (clk),
         .reset     (reset),
         .preset    (st.cr[g]),
         .load_req  (load_req[g]),
         .count_en  (count_en[g]),
         .clk_pulse (pulse[g]),
         .count     (live[g]),
         .load_done (ce_done[g])
      );
   end

   logic [1:0] port;
   logic       sel_ok;
   logic       wr_go;
   logic       rd_go;
   logic       rd_done;
   logic [1:0] fmt;
   logic [1:0] cw_sel;
   logic [1:0] cw_fmt;

   always_comb begin
      next_st         = st;
      next_st.written = '0;
      next_st.mode_wr = '0;
      next_st.wr_n_d  = wr_n;
      next_st.rd_n_d  = rd_n;
      port    = {port_sel_hi, port_sel_lo};
      sel_ok  = !chip_sel_n;
      cw_sel  = data_in[CW_SEL_LSB+1:CW_SEL_LSB];
      cw_fmt  = data_in[CW_FMT_LSB+1:CW_FMT_LSB];
      wr_go   = sel_ok && st.wr_n_d && !wr_n && rd_n;
      rd_go   = sel_ok && !rd_n && wr_n && port != PORT_CTRL;
      rd_done = sel_ok && !st.rd_n_d && rd_n && port != PORT_CTRL;
      fmt     = FMT_LATCH;

      // The snapshot follows the live count while nothing is latched.
      for (int i = 0; i < NUM_CTR; i++) begin
         if (!st.cnt_lat[i]) begin
            next_st.ol[i] = live[i];
         end
         if (ce_done[i]) begin
            next_st.null_cnt[i] = 1'b0;
         end
      end

      // Read data is registered, so it appears one cycle after the strobe.
      next_st.data_out  = ZERO_BYTE;
      next_st.data_oe_n = !rd_go;
      for (int i = 0; i < NUM_CTR; i++) begin
         if (port == 2'(i)) begin
            fmt = st.ctrl[i][CW_FMT_LSB+1:CW_FMT_LSB];
            // Only a taken read drives a byte; the bus reads as zero otherwise.
            if (!rd_go) begin
               next_st.data_out = ZERO_BYTE;
            end else if (st.sts_lat[i]) begin
               next_st.data_out = st.sts[i];
            end else if (itrp_high_byte(fmt, st.rd_ptr[i])) begin
               next_st.data_out = st.ol[i][15:8];
            end else begin
               next_st.data_out = st.ol[i][7:0];
            end
            // The end of a read advances only the read sequence.
            if (rd_done) begin
               if (st.sts_lat[i]) begin
                  next_st.sts_lat[i] = 1'b0;
               end else if (itrp_two_byte(fmt) && st.rd_ptr[i] == ITRP_BYTE_LOW) begin
                  next_st.rd_ptr[i] = ITRP_BYTE_HIGH;
               end else begin
                  next_st.rd_ptr[i]  = ITRP_BYTE_LOW;
                  next_st.cnt_lat[i] = 1'b0;
               end
            end
         end
      end

      // Count bytes go to the holding register in the programmed format.
      if (wr_go && port != PORT_CTRL) begin
         for (int i = 0; i < NUM_CTR; i++) begin
            if (port == 2'(i)) begin
               fmt = st.ctrl[i][CW_FMT_LSB+1:CW_FMT_LSB];
               case (fmt)
                  FMT_LOW: begin
                     next_st.cr[i]       = {ZERO_BYTE, data_in};
                     next_st.null_cnt[i] = 1'b1;
                     next_st.written[i]  = 1'b1;
                  end
                  FMT_HIGH: begin
                     next_st.cr[i]       = {data_in, ZERO_BYTE};
                     next_st.null_cnt[i] = 1'b1;
                     next_st.written[i]  = 1'b1;
                  end
                  FMT_BOTH: begin
                     if (st.wr_ptr[i] == ITRP_BYTE_LOW) begin
                        next_st.cr[i][7:0] = data_in;
                        next_st.wr_ptr[i]  = ITRP_BYTE_HIGH;
                     end else begin
                        next_st.cr[i][15:8] = data_in;
                        next_st.wr_ptr[i]   = ITRP_BYTE_LOW;
                        next_st.null_cnt[i] = 1'b1;
                        next_st.written[i]  = 1'b1;
                     end
                  end
                  default: begin
                     next_st.cr[i] = st.cr[i];
                  end
               endcase
            end
         end
      end

      // Control port: mode word, latch request or read-back.
      if (wr_go && port == PORT_CTRL) begin
         for (int i = 0; i < NUM_CTR; i++) begin
            if (cw_sel == SEL_RDBACK) begin
               if (data_in[RB_SEL_LSB+i]) begin
                  if (!data_in[RB_COUNT_N] && !st.cnt_lat[i]) begin
                     next_st.cnt_lat[i] = 1'b1;
                     next_st.ol[i]      = live[i];
                  end
                  if (!data_in[RB_STATUS_N] && !st.sts_lat[i]) begin
                     next_st.sts_lat[i] = 1'b1;
                     next_st.sts[i]     = {out_level[i], st.null_cnt[i], st.ctrl[i]};
                  end
               end
            end else if (cw_sel == 2'(i)) begin
               if (cw_fmt == FMT_LATCH) begin
                  if (!st.cnt_lat[i]) begin
                     next_st.cnt_lat[i] = 1'b1;
                     next_st.ol[i]      = live[i];
                  end
               end else begin
                  next_st.ctrl[i]     = data_in[CW_FIELD_W-1:0];
                  next_st.null_cnt[i] = 1'b1;
                  next_st.cnt_lat[i]  = 1'b0;
                  next_st.sts_lat[i]  = 1'b0;
                  next_st.rd_ptr[i]   = ITRP_BYTE_LOW;
                  next_st.wr_ptr[i]   = ITRP_BYTE_LOW;
                  next_st.mode_wr[i]  = 1'b1;
                  if (!itrp_two_byte(cw_fmt)) begin
                     next_st.cr[i] = ZERO_COUNT;
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st           <= '0;
         st.ctrl      <= {NUM_CTR{CTRL_RESET}};
         st.rd_ptr    <= {NUM_CTR{ITRP_BYTE_LOW}};
         st.wr_ptr    <= {NUM_CTR{ITRP_BYTE_LOW}};
         st.wr_n_d    <= 1'b1;
         st.rd_n_d    <= 1'b1;
         st.data_oe_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign data_out      = st.data_out;
   assign data_oe_n     = st.data_oe_n;
   assign clk_pulse     = pulse;
   assign load_done     = ce_done;
   assign count_written = st.written;
   assign mode_written  = st.mode_wr;
   assign mode_word     = st.ctrl;
endmodule // itrp_host_port
`default_nettype wire

// ### itrp_host_port_monitor.sv
// Purpose: Checker for the interval timer host port.
// Assumes: Bound to the host port; a single clock domain.
// Notes:   Watches bus decode, counter events and mode word updates.
`timescale 1ns/1ps
`default_nettype none
module itrp_host_port_monitor (
   // Clock and reset.
   input wire logic        clk,
   input wire logic        reset,
   // Processor bus.
   input wire logic        chip_sel_n,
   input wire logic        rd_n,
   input wire logic        wr_n,
   input wire logic        port_sel_hi,
   input wire logic        port_sel_lo,
   input wire logic [7:0]  data_in,
   input wire logic [7:0]  data_out,
   input wire logic        data_oe_n,
   // Counter side.
   input wire logic [2:0]  timer_clk,
   input wire logic [2:0]  gate,
   input wire logic [2:0]  load_req,
   input wire logic [2:0]  clk_pulse,
   input wire logic [2:0]  trigger,
   input wire logic [2:0]  load_done,
   input wire logic [2:0]  count_written,
   input wire logic [2:0]  mode_written,
   input wire logic [17:0] mode_word
);
   import itrp_pkg::*;
   logic       wr_prev;
   logic       take;
   logic [1:0] port;
   assign port = {port_sel_hi, port_sel_lo};
   // A write counts once, on the edge where the strobe is first seen low.
   assign take = !chip_sel_n && !wr_n && wr_prev && rd_n;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_prev <= 1'b1;
      end else begin
         wr_prev <= wr_n;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);
   a_trig_gate_rise: assert property ($rose(gate[1]) |=> trigger[1])
      else $error("trigger missing after gate rise");
   a_trig_cause: assert property (trigger[1] |-> $past(gate[1]) && !$past(gate[1], 2))
      else $error("trigger without gate rise");
   a_pulse_after_fall: assert property ($fell(timer_clk[0]) |=> clk_pulse[0])
      else $error("clock pulse missing after fall");
   a_pulse_needs_rise: assert property (clk_pulse[0] |-> $past(timer_clk[0], 2) && !$past(timer_clk[0]))
      else $error("clock pulse without rise then fall");
   a_load_on_pulse: assert property (clk_pulse[0] && load_req[0] |=> load_done[0])
      else $error("load missing on clock pulse");
   a_load_cause: assert property (load_done[0] |-> $past(clk_pulse[0] && load_req[0]))
      else $error("load without clock pulse");
   a_read_drive: assert property (!chip_sel_n && !rd_n && wr_n && port != 2'h3 |=> !data_oe_n)
      else $error("bus not driven on counter read");
   a_bus_release: assert property (rd_n || chip_sel_n || port == 2'h3 |=> data_oe_n)
      else $error("bus driven without read");
   a_idle_zero: assert property (data_oe_n |-> data_out == 8'h00)
      else $error("data not zero while released");
   a_mode_update: assert property (take && port == 2'h3 && data_in[7:6] != 2'h3 && data_in[5:4] != 2'h0
      |=> mode_written == (3'b001 << $past(data_in[7:6]))
      && mode_word[$past(data_in[7:6]) * 6 +: 6] == $past(data_in[5:0]))
      else $error("mode word not taken");
   a_mode_keep: assert property (take && (port != 2'h3 || data_in[5:4] == 2'h0 || data_in[7:6] == 2'h3)
      |=> mode_written == 3'b000 && $stable(mode_word))
      else $error("mode changed by count or command");
   a_count_cause: assert property (count_written[0] |-> $past(take && port == 2'h0))
      else $error("count written without write");
endmodule // itrp_host_port_monitor
bind itrp_host_port itrp_host_port_monitor i_mon (
   .clk(clk), .reset(reset), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
   .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .data_in(data_in),
   .data_out(data_out), .data_oe_n(data_oe_n), .timer_clk(timer_clk), .gate(gate),
   .load_req(load_req), .clk_pulse(clk_pulse), .trigger(trigger), .load_done(load_done),
   .count_written(count_written), .mode_written(mode_written), .mode_word(mode_word)
);
`default_nettype wire

// ### itrp_bus_model.sv
// Purpose: Processor bus master facing the timer host port.
// Assumes: Inputs change on the falling clock edge.
// Notes:   Released data lines carry the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module itrp_bus_model (
   // Clock.
   input  wire logic       clk,
   // Bus.
   output logic            chip_sel_n,
   output logic            rd_n,
   output logic            wr_n,
   output logic            port_sel_hi,
   output logic            port_sel_lo,
   output logic      [7:0] data_in,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe_n
);
   initial begin
      {chip_sel_n, rd_n, wr_n, port_sel_hi, port_sel_lo} = 5'h1C;
      data_in = 8'h00;
   end
   // Each call finishes before the next starts, so no two bus cycles overlap.
   task automatic wr(input logic [1:0] port, input logic [7:0] d);
      @(negedge clk);
      {chip_sel_n, wr_n, port_sel_hi, port_sel_lo, data_in} = {2'b00, port, d};
      @(negedge clk);
      {chip_sel_n, wr_n} = 2'b11;
      data_in = ~d;
   endtask
   // Returns the drive flag above the byte; select stays on while the strobe rises.
   task automatic rd(input logic [1:0] port, output logic [8:0] d);
      @(negedge clk);
      {chip_sel_n, rd_n, port_sel_hi, port_sel_lo} = {2'b00, port};
      @(negedge clk);
      d = {data_oe_n, data_out};
      rd_n = 1'b1;
      @(negedge clk);
      chip_sel_n = 1'b1;
   endtask
endmodule // itrp_bus_model
`default_nettype wire

// ### itrp_host_port_test.sv
// Purpose: Self-checking bench for the timer host port.
// Assumes: Bus model and counter pins driven on the falling edge.
// Notes:   Counter clocks are pulsed by hand; mode logic is stood in for.
`timescale 1ns/1ps
`default_nettype none
module itrp_host_port_test;
   import itrp_pkg::*;
   logic        clk, reset, chip_sel_n, rd_n, wr_n, port_sel_hi, port_sel_lo, data_oe_n;
   logic [7:0]  data_in, data_out;
   logic [2:0]  timer_clk, gate, out_level, load_req, count_en;
   logic [2:0]  clk_pulse, trigger, load_done, count_written, mode_written;
   logic [17:0] mode_word;
   logic [8:0]  rv;
   int          failures = 0;
   int          num_checks = 0;
   itrp_bus_model i_host (.clk(clk), .chip_sel_n(chip_sel_n), .rd_n(rd_n), .wr_n(wr_n),
      .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .data_in(data_in),
      .data_out(data_out), .data_oe_n(data_oe_n));
   itrp_host_port i_dut (.clk(clk), .reset(reset), .chip_sel_n(chip_sel_n), .rd_n(rd_n),
      .wr_n(wr_n), .port_sel_hi(port_sel_hi), .port_sel_lo(port_sel_lo), .data_in(data_in),
      .data_out(data_out), .data_oe_n(data_oe_n), .timer_clk(timer_clk), .gate(gate),
      .out_level(out_level), .load_req(load_req), .count_en(count_en), .clk_pulse(clk_pulse),
      .trigger(trigger), .load_done(load_done), .count_written(count_written),
      .mode_written(mode_written), .mode_word(mode_word));
   task automatic tally_and_finish;
      $display("checks=%0d failures=%0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      num_checks++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic rchk(input logic [1:0] port, input logic [7:0] exp);
      i_host.rd(port, rv);
      chk(rv, {1'b0, exp});
   endtask
   task automatic tick(input int i);
      @(negedge clk);
      timer_clk[i] = 1'b1;
      @(negedge clk);
      chk(clk_pulse, 3'b000);
      timer_clk[i] = 1'b0;
      @(negedge clk);
      chk(clk_pulse, 3'b001 << i);
      @(negedge clk);
      chk(load_done, load_req & (3'b001 << i));
      @(negedge clk);
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #50000;
      failures++;
      tally_and_finish();
   end
   initial begin
      {reset, timer_clk, gate, out_level, load_req, count_en} = 16'h8047;
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset = 1'b0;
      i_host.wr(2'h3, 8'h34);
      chk(mode_written, 3'b001);
      chk(mode_word[5:0], 6'h34);
      i_host.wr(2'h0, 8'h34);
      chk(count_written, 3'b000);
      i_host.wr(2'h0, 8'h12);
      chk(count_written, 3'b001);
      i_host.wr(2'h3, 8'hE2);
      rchk(2'h0, 8'hF4);
      load_req = 3'b001;
      tick(0);
      load_req = 3'b000;
      i_host.wr(2'h3, 8'hE2);
      rchk(2'h0, 8'hB4);
      $display("test program_status done");
      i_host.wr(2'h3, 8'h00);
      tick(0);
      i_host.wr(2'h3, 8'h00);
      rchk(2'h0, 8'h34);
      rchk(2'h0, 8'h12);
      rchk(2'h0, 8'h33);
      rchk(2'h0, 8'h12);
      tick(0);
      i_host.wr(2'h3, 8'hC2);
      tick(0);
      out_level = 3'b000;
      i_host.wr(2'h3, 8'hE2);
      rchk(2'h0, 8'hB4);
      rchk(2'h0, 8'h32);
      i_host.wr(2'h0, 8'h78);
      rchk(2'h0, 8'h12);
      i_host.wr(2'h0, 8'h56);
      chk(count_written, 3'b001);
      rchk(2'h0, 8'h31);
      rchk(2'h0, 8'h12);
      $display("test latch_interleave done");
      i_host.wr(2'h3, 8'h10);
      i_host.wr(2'h0, 8'h77);
      chk(mode_word[5:0], 6'h10);
      load_req = 3'b111;
      tick(0);
      i_host.wr(2'h3, 8'h20);
      i_host.wr(2'h3, 8'h50);
      i_host.wr(2'h1, 8'hAB);
      tick(1);
      i_host.wr(2'h3, 8'hA0);
      i_host.wr(2'h2, 8'h5A);
      tick(2);
      load_req = 3'b000;
      i_host.wr(2'h3, 8'hDE);
      tick(1);
      i_host.wr(2'h3, 8'hDC);
      rchk(2'h1, 8'hAB);
      rchk(2'h2, 8'h5A);
      rchk(2'h0, 8'h00);
      rchk(2'h1, 8'hAA);
      chk({data_oe_n, data_out}, 9'h100);
      $display("test multi_snapshot done");
      i_host.rd(2'h3, rv);
      chk(rv, 9'h100);
      i_host.wr(2'h3, 8'h80);
      chk(mode_word[17:12], 6'h20);
      gate = 3'b111;
      @(negedge clk);
      chk(trigger, 3'b111);
      @(negedge clk);
      chk(trigger, 3'b000);
      $display("test decode_trigger done");
      tally_and_finish();
   end
endmodule // itrp_host_port_test
`default_nettype wire
